// ### src/odbt_pkg.sv
// shared constants and types for the output drum buffer transfer block
package odbt_pkg;
    // clock and drum timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_NS = 10000;
    localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int PHASE_SPACING_NS = 2500;
    localparam int PHASE_CYCLES = PHASE_SPACING_NS / CLK_PERIOD_NS;
    localparam int PHASE_LOST_CYCLES = 2 * PHASE_CYCLES;
    localparam int FIELD_GAP_NS = 120000;
    localparam int WORD_SPACING_NS = 20000;
    localparam int ARRAY_GAP_SLOTS = WORD_SPACING_NS / SLOT_TIME_NS;
    localparam int ARRAY_GAP_CYCLES = ARRAY_GAP_SLOTS * SLOT_CYCLES;
    // buffer fields
    localparam int NUM_FIELDS = 3;
    localparam int FIELD_SLOTS = 2048;
    localparam int USABLE_SLOTS = 2036;
    localparam int DEAD_SLOTS = FIELD_GAP_NS / SLOT_TIME_NS;
    localparam int SLOT_W = 11;
    localparam int FIELD_W = 2;
    // drum word layout
    localparam int WORD_W = 33;
    localparam int PARITY_BIT = 32;
    localparam int SECT_MSB = 31;
    localparam int SECT_LSB = 29;
    localparam int REG_MSB = 28;
    localparam int REG_LSB = 24;
    localparam int BURST_MSB = 23;
    localparam int BURST_LSB = 16;
    localparam int RIGHT_W = 16;
    localparam int SECT_W = SECT_MSB - SECT_LSB + 1;
    localparam int REG_W = REG_MSB - REG_LSB + 1;
    localparam int BURST_W = BURST_MSB - BURST_LSB + 1;
    // core array and buffer
    localparam int ARRAY_ROWS = 26;
    localparam int ARRAY_COLS = 22;
    localparam int ROW_W = 5;
    localparam int COL_W = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = REG_W + RIGHT_W;
    // teleprinter class symbols
    localparam logic [4:0] TELE_SPACE = 5'h1b;
    localparam logic [4:0] TELE_CR = 5'h1d;
    localparam logic [4:0] TELE_LF = 5'h17;
    localparam logic [4:0] TELE_FIGS = 5'h04;
    localparam logic [4:0] TELE_LTRS = 5'h00;

    typedef logic [WORD_W-1:0] odbt_word_t;
    typedef enum logic [1:0] {
        ODBT_PH_ONE,
        ODBT_PH_TWO,
        ODBT_PH_THREE,
        ODBT_PH_FOUR
    } odbt_phase_t;
endpackage : odbt_pkg

// ### src/odbt_wr_if.sv
// write-in path from the transfer logic into the core array
interface odbt_wr_if;
    logic valid;
    logic ready;
    logic [odbt_pkg::ROW_W-1:0] row;
    logic [odbt_pkg::ARRAY_COLS-1:0] bits;
    modport src (output valid, output row, output bits, input ready);
    modport dst (input valid, input row, input bits, output ready);
endinterface : odbt_wr_if

// ### src/odbt_fifo.sv
// small flip-flop fifo with valid/ready on both sides
module odbt_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    a_fifo_no_over: assert property (@(posedge clk) disable iff (sys_rst)
        cnt_q == (AW+1)'(DEPTH) |-> !push)
        else $error("fifo written while full");
endmodule : odbt_fifo

// ### src/odbt_core_array.sv
// 26 x 22 coincident-select storage array with destructive column readout
module odbt_core_array
    import odbt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    odbt_wr_if.dst wr,
    input wire logic rd_start,
    input wire logic rd_step,
    output logic [odbt_pkg::ARRAY_ROWS-1:0] col_bits_q,
    output logic [odbt_pkg::COL_W-1:0] col_index_q,
    output logic col_valid_q,
    output logic rd_busy_q
);
    logic [ARRAY_COLS-1:0] mem_q [ARRAY_ROWS];
    logic [COL_W-1:0] col_q;
    logic [ARRAY_ROWS-1:0] sense;
    logic last_col;

    assign wr.ready = !rd_busy_q;
    assign last_col = col_q == COL_W'(ARRAY_COLS - 1);

    always_comb
    begin
        for (int r = 0; r < ARRAY_ROWS; r++)
        begin
            sense[r] = mem_q[r][col_q];
        end
    end

    // bit set only where row select and column select coincide
    always_ff @(posedge clk)
    begin
        for (int r = 0; r < ARRAY_ROWS; r++)
        begin
            for (int c = 0; c < ARRAY_COLS; c++)
            begin
                if (sys_rst)
                begin
                    mem_q[r][c] <= 1'b0;
                end
                else if (rd_busy_q && rd_step && col_q == COL_W'(c))
                begin
                    mem_q[r][c] <= 1'b0; // see RULE_18
                end
                else if (wr.valid && !rd_busy_q &&
                         wr.row == ROW_W'(r) && wr.bits[c])
                begin
                    mem_q[r][c] <= 1'b1; // see RULE_17
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_busy_q <= 1'b0;
            col_q <= '0;
            col_valid_q <= 1'b0;
            col_bits_q <= '0;
            col_index_q <= '0;
        end
        else
        begin
            col_valid_q <= 1'b0;
            if (!rd_busy_q && rd_start)
            begin
                rd_busy_q <= 1'b1;
                col_q <= '0;
            end
            else if (rd_busy_q && rd_step)
            begin
                col_bits_q <= sense; // see RULE_18
                col_index_q <= col_q;
                col_valid_q <= 1'b1;
                col_q <= last_col ? '0 : col_q + 1'b1;
                rd_busy_q <= !last_col;
            end
        end
    end

    a_col_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        rd_busy_q && rd_step |=> mem_q[0][col_index_q] == 1'b0) // see RULE_18
        else $error("read column not cleared");
    a_no_stray_set: assert property (@(posedge clk) disable iff (sys_rst)
        !wr.valid && !mem_q[3][5] |=> !mem_q[3][5]) // see RULE_17
        else $error("array bit set without selection");
endmodule : odbt_core_array

// ### src/odbt_transfer.sv
// drum buffer field reader: slot timing, word check, status and array feed
// Overview of operation
// RULE_01 - three fields form one track; 2048 slots each, first 12 dead.
// RULE_02 - no reading in the 120 us field-switch gap of dead slots.
// RULE_03 - one slot passes every 10 us timing cycle.
// RULE_04 - writer keeps one message on only odd or only even slots.
// RULE_05 - writer spaces message words by multiples of 20 us.
// RULE_06 - feed one array no faster than 50000 words per second.
// RULE_07 - writer uses first available slot of its odd/even set.
// RULE_08 - written slot is unavailable; consumed slot becomes available again.
// RULE_09 - no erase of consumed slots; later writes overwrite them.
// RULE_10 - examine every slot in order, up to 100000 words per second.
// RULE_11 - each word is accepted, erroneous or early, exactly one.
// RULE_12 - accepted and erroneous free the slot; early words keep it.
// RULE_13 - words wait on the drum until their burst period starts.
// RULE_14 - drum sends four phase pulses 2.5 us apart, repeating.
// RULE_15 - all reception steps are paced by the drum phase pulses.
// RULE_16 - storage array of 22 columns by 26 row registers.
// RULE_17 - array bit set only where row and column selects coincide.
// RULE_18 - array read one column at a time, destructively, bit per row.
// RULE_19 - teleprinter symbols are 5-bit codes with letters/figures shift.
// RULE_20 - odd count of ones in 33-bit word accepts; even rejects.
// RULE_21 - writer gives every word of a message the same burst number.
// RULE_22 - burst number differing from current burst count means not due.
module odbt_transfer
    import odbt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic drum_phase_pulse_one,
    input wire logic drum_phase_pulse_two,
    input wire logic drum_phase_pulse_three,
    input wire logic drum_phase_pulse_four,
    input wire logic field_mark,
    input wire odbt_pkg::odbt_word_t drum_word,
    input wire logic slot_unavailable,
    input wire logic [odbt_pkg::BURST_W-1:0] burst_count,
    input wire logic [odbt_pkg::SECT_W-1:0] own_section,
    input wire logic readout_start,
    output logic [odbt_pkg::SLOT_W-1:0] slot_index_q,
    output logic [odbt_pkg::FIELD_W-1:0] field_index_q,
    output logic slot_live_q,
    output logic status_set_avail_q,
    output logic word_accepted_q,
    output logic word_error_q,
    output logic word_early_q,
    output logic figures_shift_q,
    output logic phase_fault_q,
    output logic [odbt_pkg::ARRAY_ROWS-1:0] col_bits_q,
    output logic [odbt_pkg::COL_W-1:0] col_index_q,
    output logic col_valid_q,
    output logic readout_busy_q
);
    import odbt_pkg::*;

    odbt_wr_if wr_bus ();

    odbt_phase_t expect_q;
    logic [9:0] watchdog_q;
    logic [3:0] phase_vec;
    logic [3:0] expect_vec;
    logic any_phase;
    logic synced_q;
    logic last_slot;
    logic examine;
    logic ours;
    logic parity_odd;
    logic burst_due;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;
    logic [1:0] gap_slots_q;
    logic array_fire;
    logic take_word;

    // phase order supervision
    assign phase_vec = {drum_phase_pulse_four, drum_phase_pulse_three,
                        drum_phase_pulse_two, drum_phase_pulse_one};
    assign any_phase = |phase_vec;

    always_comb
    begin
        unique case (expect_q)
            ODBT_PH_ONE: expect_vec = 4'h1;
            ODBT_PH_TWO: expect_vec = 4'h2;
            ODBT_PH_THREE: expect_vec = 4'h4;
            ODBT_PH_FOUR: expect_vec = 4'h8;
        endcase
    end

    // phase one always resyncs, so one glitch costs only a fault flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            expect_q <= ODBT_PH_ONE;
        end
        else if (drum_phase_pulse_one)
        begin
            expect_q <= ODBT_PH_TWO; // see RULE_15
        end
        else if (any_phase)
        begin
            unique case (expect_q)
                ODBT_PH_ONE: expect_q <= ODBT_PH_TWO;
                ODBT_PH_TWO: expect_q <= ODBT_PH_THREE;
                ODBT_PH_THREE: expect_q <= ODBT_PH_FOUR;
                ODBT_PH_FOUR: expect_q <= ODBT_PH_ONE;
            endcase
        end
    end

    // sticky until reset: a drum that stalls or skips a phase is broken
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            watchdog_q <= '0;
            phase_fault_q <= 1'b0;
        end
        else
        begin
            if (any_phase)
            begin
                watchdog_q <= '0;
            end
            else if (watchdog_q != 10'(PHASE_LOST_CYCLES))
            begin
                watchdog_q <= watchdog_q + 1'b1;
            end
            if ((any_phase && phase_vec != expect_vec && synced_q) ||
                watchdog_q == 10'(PHASE_LOST_CYCLES))
            begin
                phase_fault_q <= 1'b1; // see RULE_14
            end
        end
    end

    // slot and field position, advanced once per drum cycle
    assign last_slot = slot_index_q == SLOT_W'(FIELD_SLOTS - 1);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            slot_index_q <= '0;
            field_index_q <= '0;
            synced_q <= 1'b0;
        end
        else if (drum_phase_pulse_one)
        begin
            if (field_mark)
            begin
                slot_index_q <= '0;
                field_index_q <= '0;
                synced_q <= 1'b1;
            end
            else if (last_slot)
            begin
                slot_index_q <= '0; // see RULE_01
                field_index_q <= field_index_q == FIELD_W'(NUM_FIELDS - 1) ?
                    '0 : field_index_q + 1'b1;
            end
            else
            begin
                slot_index_q <= slot_index_q + 1'b1; // see RULE_03
            end
        end
    end

    // dead slots at each field start cover the switch gap
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            slot_live_q <= 1'b0;
        end
        else
        begin
            slot_live_q <= synced_q &&
                slot_index_q >= SLOT_W'(DEAD_SLOTS); // see RULE_02
        end
    end

    // word examination at phase two of every live slot marked unavailable
    assign examine = drum_phase_pulse_two && slot_live_q &&
                     slot_unavailable; // see RULE_10
    assign ours = drum_word[SECT_MSB:SECT_LSB] == own_section;
    assign parity_odd = ^drum_word; // see RULE_20
    assign burst_due = drum_word[BURST_MSB:BURST_LSB] ==
                       burst_count; // see RULE_22
    // a full buffer leaves the word on the drum, like an early word
    assign take_word = examine && ours && parity_odd && burst_due &&
                       fifo_in_ready; // see RULE_13

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            word_accepted_q <= 1'b0;
            word_error_q <= 1'b0;
            word_early_q <= 1'b0;
            status_set_avail_q <= 1'b0;
        end
        else
        begin
            word_accepted_q <= take_word; // see RULE_11
            word_error_q <= examine && ours && !parity_odd;
            word_early_q <= examine && ours && parity_odd && !take_word;
            // see RULE_08, RULE_09, RULE_12
            status_set_avail_q <= take_word ||
                (examine && ours && !parity_odd);
        end
    end

    // letters/figures shift follows the last shift symbol taken
    function automatic logic next_shift(input logic cur,
                                        input logic [14:0] syms);
        logic s;
        s = cur;
        for (int i = 2; i >= 0; i--)
        begin
            if (syms[i*5 +: 5] == TELE_FIGS)
            begin
                s = 1'b1;
            end
            else if (syms[i*5 +: 5] == TELE_LTRS)
            begin
                s = 1'b0;
            end
        end
        return s;
    endfunction : next_shift

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            figures_shift_q <= 1'b0;
        end
        else if (take_word)
        begin
            figures_shift_q <= next_shift(figures_shift_q,
                                          drum_word[14:0]); // see RULE_19
        end
    end

    odbt_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(take_word),
        .in_ready(fifo_in_ready),
        .in_data({drum_word[REG_MSB:REG_LSB], drum_word[RIGHT_W-1:0]}),
        .out_valid(fifo_out_valid),
        .out_ready(array_fire),
        .out_data(fifo_out_data)
    );

    // array feed: at most one word every two drum cycles
    assign array_fire = fifo_out_valid && wr_bus.ready &&
        drum_phase_pulse_four &&
        gap_slots_q >= 2'(ARRAY_GAP_SLOTS); // see RULE_06
    assign wr_bus.valid = array_fire;
    assign wr_bus.row = fifo_out_data[FIFO_W-1:RIGHT_W];
    assign wr_bus.bits = {{(ARRAY_COLS - RIGHT_W){1'b0}},
                          fifo_out_data[RIGHT_W-1:0]};

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            gap_slots_q <= 2'(ARRAY_GAP_SLOTS);
        end
        else if (array_fire)
        begin
            gap_slots_q <= '0;
        end
        else if (drum_phase_pulse_one &&
                 gap_slots_q != 2'(ARRAY_GAP_SLOTS))
        begin
            gap_slots_q <= gap_slots_q + 1'b1; // see RULE_15
        end
    end

    odbt_core_array u_array (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(wr_bus.dst), // see RULE_16
        .rd_start(readout_start),
        .rd_step(drum_phase_pulse_three),
        .col_bits_q(col_bits_q),
        .col_index_q(col_index_q),
        .col_valid_q(col_valid_q),
        .rd_busy_q(readout_busy_q)
    );

    // checking helpers
    logic [11:0] since_fire_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            since_fire_q <= 12'(ARRAY_GAP_CYCLES);
        end
        else if (array_fire)
        begin
            // counts the fire edge itself, so the count equals the spacing
            since_fire_q <= 12'h001;
        end
        else if (since_fire_q != 12'(ARRAY_GAP_CYCLES))
        begin
            since_fire_q <= since_fire_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_examined;
        examine && ours;
    endsequence
    sequence s_freed;
        ##1 status_set_avail_q;
    endsequence
    sequence s_kept;
        ##1 !status_set_avail_q;
    endsequence

    a_dead_silent: assert property ( // see RULE_02
        status_set_avail_q |-> $past(slot_live_q))
        else $error("status changed in a dead slot");
    a_one_outcome: assert property ( // see RULE_11
        $onehot0({word_accepted_q, word_error_q, word_early_q}))
        else $error("word has more than one outcome");
    a_error_frees: assert property ( // see RULE_12
        s_examined ##0 !parity_odd |-> s_freed)
        else $error("erroneous word did not free slot");
    a_early_keeps: assert property ( // see RULE_12
        s_examined ##0 (parity_odd && !burst_due) |-> s_kept ##0 word_early_q)
        else $error("early word freed its slot");
    a_parity_even: assert property ( // see RULE_20
        word_error_q |-> !(^$past(drum_word)))
        else $error("odd word marked erroneous");
    a_burst_due: assert property ( // see RULE_13
        word_accepted_q |-> $past(drum_word[BURST_MSB:BURST_LSB]) ==
            $past(burst_count))
        else $error("word accepted outside its burst");
    a_array_rate: assert property ( // see RULE_06
        array_fire |-> since_fire_q == 12'(ARRAY_GAP_CYCLES))
        else $error("array fed faster than allowed");
    a_slot_step: assert property ( // see RULE_03
        drum_phase_pulse_one && !field_mark && !last_slot |=>
            slot_index_q == $past(slot_index_q) + 1'b1)
        else $error("slot did not advance");
    a_field_wrap: assert property ( // see RULE_01
        drum_phase_pulse_one && !field_mark && last_slot |=>
            slot_index_q == '0 && field_index_q != $past(field_index_q))
        else $error("field did not change at wrap");
    a_ignored_idle: assert property ( // see RULE_10
        !drum_phase_pulse_two |=> !word_accepted_q && !word_error_q)
        else $error("word classified outside phase two");
endmodule : odbt_transfer

// ### tb/odbt_drum_model.sv
// behavioural drum side: phase pulses, field mark and the word under the head
module odbt_drum_model
    import odbt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mark_req,
    input wire odbt_pkg::odbt_word_t word_in,
    input wire logic unavail_in,
    output logic drum_phase_pulse_one,
    output logic drum_phase_pulse_two,
    output logic drum_phase_pulse_three,
    output logic drum_phase_pulse_four,
    output logic field_mark,
    output odbt_pkg::odbt_word_t drum_word,
    output logic slot_unavailable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cnt_q;
    logic run_q;
    logic in_win;

    // one slot per 1000 cycles, pulses 250 cycles apart
    always_ff @(posedge clk)
    begin
        run_q <= !sys_rst;
        if (sys_rst)
            cnt_q <= 10'h3e7;
        else
            cnt_q <= (cnt_q == 10'h3e7) ? 10'h000 : cnt_q + 10'h001;
    end
    assign drum_phase_pulse_one = run_q && cnt_q == 10'h000;
    assign drum_phase_pulse_two = run_q && cnt_q == 10'h0fa;
    assign drum_phase_pulse_three = run_q && cnt_q == 10'h1f4;
    assign drum_phase_pulse_four = run_q && cnt_q == 10'h2ee;
    assign field_mark = drum_phase_pulse_one && mark_req;
    // outside the read window the head shows garbage, not the last word
    assign in_win = cnt_q >= 10'h0c8 && cnt_q <= 10'h12c;
    assign drum_word = in_win ? word_in : ~word_in;
    assign slot_unavailable = in_win ? unavail_in : ~unavail_in;
endmodule : odbt_drum_model

// ### tb/tb.sv
// self-checking bench for the drum buffer transfer block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import odbt_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic mark_req = 1'b0;
    odbt_word_t word_in = '0;
    logic unavail_in = 1'b0;
    logic [BURST_W-1:0] burst_count = 8'h05;
    logic [SECT_W-1:0] own_section = 3'h2;
    logic readout_start = 1'b0;
    logic ph1, ph2, ph3, ph4, field_mark, slot_unavailable;
    odbt_word_t drum_word;
    logic [SLOT_W-1:0] slot_index_q;
    logic [FIELD_W-1:0] field_index_q;
    logic slot_live_q, status_set_avail_q, word_accepted_q, word_error_q;
    logic word_early_q, figures_shift_q, phase_fault_q, col_valid_q;
    logic readout_busy_q;
    logic [ARRAY_ROWS-1:0] col_bits_q;
    logic [COL_W-1:0] col_index_q;
    logic [ARRAY_ROWS-1:0] cap [ARRAY_COLS];
    int err_total = 0;
    int compares = 0;
    int ncol = 0;

    always #5 clk = ~clk;

    odbt_drum_model drum (.clk(clk), .sys_rst(sys_rst), .mark_req(mark_req),
        .word_in(word_in), .unavail_in(unavail_in),
        .drum_phase_pulse_one(ph1), .drum_phase_pulse_two(ph2),
        .drum_phase_pulse_three(ph3), .drum_phase_pulse_four(ph4),
        .field_mark(field_mark), .drum_word(drum_word),
        .slot_unavailable(slot_unavailable));

    odbt_transfer uut (.clk(clk), .sys_rst(sys_rst),
        .drum_phase_pulse_one(ph1), .drum_phase_pulse_two(ph2),
        .drum_phase_pulse_three(ph3), .drum_phase_pulse_four(ph4),
        .field_mark(field_mark), .drum_word(drum_word),
        .slot_unavailable(slot_unavailable), .burst_count(burst_count),
        .own_section(own_section), .readout_start(readout_start),
        .slot_index_q(slot_index_q), .field_index_q(field_index_q),
        .slot_live_q(slot_live_q), .status_set_avail_q(status_set_avail_q),
        .word_accepted_q(word_accepted_q), .word_error_q(word_error_q),
        .word_early_q(word_early_q), .figures_shift_q(figures_shift_q),
        .phase_fault_q(phase_fault_q), .col_bits_q(col_bits_q),
        .col_index_q(col_index_q), .col_valid_q(col_valid_q),
        .readout_busy_q(readout_busy_q));

    // columns are one-cycle pulses, so capture them as they come
    always @(posedge clk)
    begin
        if (col_valid_q === 1'b1)
        begin
            cap[col_index_q] = col_bits_q;
            ncol = ncol + 1;
        end
    end

    task automatic report_and_stop;
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // odd total of ones unless bad is set
    function automatic odbt_word_t mk(input logic [2:0] s,
        input logic [4:0] r, input logic [7:0] b, input logic [15:0] d,
        input logic bad);
        odbt_word_t w;
        w = {1'b0, s, r, b, d};
        w[PARITY_BIT] = ~(^w[31:0]) ^ bad;
        return w;
    endfunction : mk

    task automatic wait_ph(input int n);
        int i;
        for (i = 0; i < 1100; i++)
        begin
            @(posedge clk);
            if ((n == 1 && ph1 === 1'b1) || (n == 2 && ph2 === 1'b1))
                return;
        end
        err_total = err_total + 1;
        report_and_stop();
    endtask : wait_ph

    // exp: accepted, error, early, status pulse
    task automatic slot(input odbt_word_t w, input logic unav,
        input logic [3:0] exp);
        word_in <= w;
        unavail_in <= unav;
        wait_ph(2);
        @(posedge clk);
        check({word_accepted_q, word_error_q, word_early_q,
            status_set_avail_q}, exp);
    endtask : slot

    task automatic start_readout;
        int c;
        for (c = 0; c < ARRAY_COLS; c++)
            cap[c] = '1;
        ncol = 0;
        readout_start <= 1'b1;
        @(posedge clk);
        readout_start <= 1'b0;
        @(posedge clk);
        check(readout_busy_q, 1);
    endtask : start_readout

    task automatic finish_readout(input logic [15:0] right);
        int i;
        for (i = 0; i < 25000 && readout_busy_q !== 1'b0; i++)
            @(posedge clk);
        if (i == 25000)
        begin
            err_total = err_total + 1;
            report_and_stop();
        end
        @(posedge clk);
        check(ncol, ARRAY_COLS);
        for (i = 0; i < ARRAY_COLS; i++)
            check(cap[i], (i < 16 && right[i]) ? 26'h8 : 26'h0);
    endtask : finish_readout

    task automatic s_reset;
        @(posedge clk);
        check({slot_index_q, field_index_q, slot_live_q, readout_busy_q,
            phase_fault_q}, 0);
        // not yet synced to a field, so nothing is examined
        slot(mk(3'h2, 5'h01, 8'h05, 16'h0000, 1'b0), 1'b1, 4'h0);
    endtask : s_reset

    task automatic s_dead;
        int i;
        mark_req <= 1'b1;
        wait_ph(1);
        mark_req <= 1'b0;
        for (i = 0; i < 12; i++)
            slot(mk(3'h2, 5'h01, 8'h05, 16'h0000, 1'b0), 1'b1, 4'h0);
        check({field_index_q, slot_index_q}, 11);
        check(slot_live_q, 0);
    endtask : s_dead

    task automatic s_classify;
        slot(mk(3'h2, 5'h03, 8'h05, 16'h9084, 1'b0), 1'b1, 4'h9);
        check(slot_index_q, 12);
        slot(mk(3'h2, 5'h04, 8'h05, 16'h0001, 1'b1), 1'b1, 4'h5);
        check(figures_shift_q, 1);
        slot(mk(3'h2, 5'h04, 8'h06, 16'h0001, 1'b0), 1'b1, 4'h2);
        slot(mk(3'h1, 5'h04, 8'h05, 16'h0001, 1'b0), 1'b1, 4'h0);
        slot(mk(3'h2, 5'h04, 8'h05, 16'h0001, 1'b0), 1'b0, 4'h0);
    endtask : s_classify

    // readout blocks array writes, so the 16-word buffer fills up
    task automatic s_fill;
        int i;
        start_readout();
        // one-word messages, each in the first slot still unavailable
        for (i = 0; i < 17; i++)
            slot(mk(3'h2, i[4:0], 8'h05, 16'h0000, 1'b0), 1'b1,
                i < 16 ? 4'h9 : 4'h2);
        finish_readout(16'h9084);
        check(figures_shift_q, 0);
        start_readout();
        finish_readout(16'h0000);
        // let the buffer drain a few words at the limited array rate
        repeat (4500) @(posedge clk);
        check(phase_fault_q, 0);
    endtask : s_fill

    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        s_reset();
        s_dead();
        s_classify();
        s_fill();
        report_and_stop();
    end
endmodule : tb
